// file: bench/epci_pin_src.sv
// Purpose: Far-side model of the sources driving the interrupt pins
// Assumes: Pins are actively driven at all times, no pull resistors
// Notes:   Levels change just after a rising edge and then stand
`timescale 1ns/1ps
`default_nettype none

module epci_pin_src (
	input  wire logic        clk_in,       // System clock
	output logic             ded_pin_out,  // Dedicated pin level
	output logic [15:0]      pc_pins_out   // Pin-change levels
);
	// ==========================================================
	// Idle levels: dedicated pin high so level mode stays quiet
	initial begin
		ded_pin_out = 1'b1;
		pc_pins_out = 16'h0000;
	end

	// ==========================================================
	// new levels held across several clock edges
	task automatic drive(input logic d, input logic [15:0] p);
		@(posedge clk_in);
		ded_pin_out <= d;
		pc_pins_out <= p;
		repeat (3) @(posedge clk_in);
	endtask
endmodule // epci_pin_src

`default_nettype wire

// file: bench/testbench.sv
// Purpose: Self-checking bench of the pin interrupt unit over APB
// Assumes: Request outputs registered, flags visible three edges on
// Notes:   Integer model of registers and flags predicts every register read
`timescale 1ns/1ps
`include "epci_defines.svh"
`default_nettype none

module testbench;
	// ==========================================================
	// Signals
	logic        clk_in, rst_in, psel, penable, pwrite, gie;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic        pready, pslverr, er, ded_pin, ded_req, up_req, lo_req, wake;
	logic [15:0] pc_pins;
	logic [2:0]  vstart;
	int          n_mismatch, n_compared, i, b;
	int          m_sense, m_en, m_flag, m_mask, m_pins, m_ded;  // Model

	epci_top epci_top_inst (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .dedicated_irq_pin_in(ded_pin),
		.pin_change_inputs_in(pc_pins), .global_irq_enable_in(gie), .vector_start_in(vstart),
		.dedicated_irq_req_out(ded_req), .upper_group_request_out(up_req),
		.lower_group_request_out(lo_req), .wake_out(wake));
	epci_pin_src epci_pin_src_inst (.clk_in(clk_in), .ded_pin_out(ded_pin), .pc_pins_out(pc_pins));

	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic final_report();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_in);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		if (k == 20) begin
			n_mismatch++;
			final_report();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Write and mirror into the model
	task automatic wr(input logic [7:0] a, input int v);
		apb(1'b1, a, v);
		case (a)
			`EPCI_OFF_SENSE:   m_sense = v & 3;
			`EPCI_OFF_ENABLE:  m_en = v & 'hc1;
			`EPCI_OFF_FLAG:    m_flag &= ~v;
			`EPCI_OFF_MASK_UP: m_mask = (m_mask & 'hff) | ((v & 'hff) << 8);
			default:           m_mask = (m_mask & 'hff00) | (v & 'hff);
		endcase
		if (m_sense == 0)
			m_flag &= 'hc0;
	endtask

	// Read every register and compare with the model image
	task automatic rdall();
		int ev[5];
		ev = '{m_sense, m_en, m_flag, m_mask >> 8, m_mask & 'hff};
		for (int j = 0; j < 5; j++) begin
			apb(1'b0, 8'(j * 4), 32'h0);
			chk(rd, ev[j], "register");
			chk({31'h0, er}, 32'h0, "error");
		end
	endtask

	// Pin stimulus with model prediction of flags
	task automatic stim(input int d, input int p);
		int ch;
		ch = (m_pins ^ p) & m_mask;
		if (ch & 'hff00)
			m_flag |= 'h80;
		if (ch & 'hff)
			m_flag |= 'h40;
		if ((m_sense == 1 && d != m_ded) || (m_sense == 2 && m_ded > d) || (m_sense == 3 && d > m_ded))
			m_flag |= 1;
		m_pins = p;
		m_ded = d;
		epci_pin_src_inst.drive(1'(d), 16'(p));
	endtask

	// Bounded wait until requests match the model
	task automatic wait_req();
		logic [2:0] e;
		int k;
		// Let an enable change made at this edge land first
		@(posedge clk_in);
		e = {m_flag[7] & m_en[7], m_flag[6] & m_en[6],
			(m_sense == 0 ? m_ded == 0 : m_flag[0]) & m_en[0]} & {3{gie}};
		for (k = 0; k < 12 && {up_req, lo_req, ded_req} !== e; k++)
			@(posedge clk_in);
		chk({29'h0, up_req, lo_req, ded_req}, {29'h0, e}, "request");
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{psel, penable, pwrite, gie, paddr, pwdata, vstart} = '0;
		{n_mismatch, n_compared, m_sense, m_en, m_flag, m_mask, m_pins} = '0;
		m_ded = 1;
		seed = 32'd55666;
		rst_in = 1'b1;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		rdall();
		apb(1'b0, 8'h14, 32'h0);
		chk({rd[30:0], er}, 32'h1, "unmapped");
		wr(`EPCI_OFF_SENSE, 'hffff_ffff);
		wr(`EPCI_OFF_MASK_UP, rnd());
		wr(`EPCI_OFF_MASK_LO, rnd());
		rdall();
		$display("test registers done");
		wr(`EPCI_OFF_ENABLE, 'hc1);
		@(posedge clk_in) gie <= 1'b1;
		for (i = 0; i < 6; i++) begin
			b = rnd() & 15;
			wr(b > 7 ? `EPCI_OFF_MASK_UP : `EPCI_OFF_MASK_LO, 1 << (b & 7));
			stim(m_ded, m_pins ^ (1 << (b ^ 1)));
			stim(m_ded, m_pins ^ (1 << b));
			rdall();
			wait_req();
			wr(`EPCI_OFF_FLAG, 0);
			rdall();
			if (i[0]) begin
				wr(`EPCI_OFF_FLAG, 'hc0);
			end else begin
				@(posedge clk_in) vstart <= 3'h6;
				@(posedge clk_in) vstart <= 3'h0;
				m_flag &= 1;
			end
			rdall();
			wait_req();
		end
		$display("test pin change done");
		for (i = 1; i < 4; i++) begin
			wr(`EPCI_OFF_SENSE, i);
			stim(0, m_pins);
			rdall();
			wait_req();
			stim(1, m_pins);
			rdall();
			wait_req();
			@(posedge clk_in) vstart <= 3'h1;
			@(posedge clk_in) vstart <= 3'h0;
			m_flag &= 'hc0;
			rdall();
		end
		$display("test edge modes done");
		stim(0, m_pins);
		wr(`EPCI_OFF_SENSE, 0);
		rdall();
		wait_req();
		chk({31'h0, wake}, 32'h1, "wake level");
		@(posedge clk_in) gie <= 1'b0;
		wait_req();
		@(posedge clk_in) gie <= 1'b1;
		stim(1, m_pins);
		wait_req();
		chk({31'h0, wake}, 32'h0, "wake idle");
		$display("test level mode done");
		final_report();
	end
endmodule // testbench

`default_nettype wire

// file: hw/epci_defines.svh
// Purpose: Constants for the external and pin-change interrupt unit
// Assumes: APB slave, 32-bit data, one 40 MHz clock
// Notes:   Types live in epci_pkg; numbers live here
//
// Overview of operation
// - Requests fire even when pins drive outputs
// - Upper group requests on unmasked input toggle
// - Lower group requests on unmasked input toggle
// - Pin changes detected without edge-clocked sensing; here sampled on clk_in through two sync stages
// - Two-bit sense: low, change, fall, rise
// - Low level requests while pin stays low
// - Edges sensed only while clock runs
// - Low level detected as plain level
// - Pin sampled; pulses over one clock caught
// - Level must outlast wake start-up time
// - Dedicated request needs enable bit 0, global
// - Group enables bits 7, 6 plus global
// - Flag bits 7, 6 mark group changes
// - Flag clears when its routine starts
// - Writing one clears flag; zero ignored
// - Flag bit 0 marks dedicated pin event
// - Dedicated flag held clear in level mode
// - Upper mask bits admit inputs 15..8
// - Lower mask needs lower group enable too
// - Groups have separate request vectors
`ifndef EPCI_DEFINES_SVH
`define EPCI_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define EPCI_OFF_SENSE      8'h00
`define EPCI_OFF_ENABLE     8'h04
`define EPCI_OFF_FLAG       8'h08
`define EPCI_OFF_MASK_UP    8'h0c
`define EPCI_OFF_MASK_LO    8'h10

// ==========================================================
// Bit positions
`define EPCI_BIT_UPPER      7
`define EPCI_BIT_LOWER      6
`define EPCI_BIT_DED        0

// ==========================================================
// Reset values and field codes
`define EPCI_RST_BYTE       8'h00
`define EPCI_RST_SENSE      2'h0
`define EPCI_SENSE_LOW      2'h0
`define EPCI_SENSE_ANY      2'h1
`define EPCI_SENSE_FALL     2'h2
`define EPCI_SENSE_RISE     2'h3
`define EPCI_ZERO_WORD      32'h0000_0000

`endif

// file: hw/epci_pkg.sv
// Purpose: Types for the external and pin-change interrupt unit
// Assumes: Used with epci_defines.svh
// Notes:   No constants here besides types
package epci_pkg;

	// ==========================================================
	// Sense selection of the dedicated pin
	typedef enum logic [1:0] {
		EPCI_LOW  = 2'h0,
		EPCI_ANY  = 2'h1,
		EPCI_FALL = 2'h2,
		EPCI_RISE = 2'h3
	} epci_sense_t;

	// ==========================================================
	// Software-visible control bundle
	typedef struct packed {
		logic [7:0] mask_up;  // Upper input admit bits
		logic [7:0] mask_lo;  // Lower input admit bits
		logic       en_up;    // Upper group enable
		logic       en_lo;    // Lower group enable
		logic       en_ded;   // Dedicated pin enable
		logic [1:0] sense;    // Dedicated pin sensing
	} epci_ctrl_t;

	// ==========================================================
	// Sticky event flags
	typedef struct packed {
		logic up;   // Upper group changed
		logic lo;   // Lower group changed
		logic ded;  // Dedicated pin event
	} epci_flags_t;

endpackage : epci_pkg

// file: hw/epci_top.sv
// Purpose: External pin and pin-change interrupt unit, APB slave
// Assumes: Pins asynchronous to clk_in; CPU acks are clk_in pulses
// Notes:   Access phase lasts two cycles; outputs all registered
`timescale 1ns/1ps
`include "epci_defines.svh"
`default_nettype none

module epci_top (
	input  wire logic        clk_in,                 // 40 MHz system clock
	input  wire logic        rst_in,                 // Async reset, high
	input  wire logic        psel_in,                // APB select
	input  wire logic        penable_in,             // APB access phase
	input  wire logic        pwrite_in,              // APB write
	input  wire logic [7:0]  paddr_in,               // APB byte address
	input  wire logic [31:0] pwdata_in,              // APB write data
	output logic      [31:0] prdata_out,             // APB read data
	output logic             pready_out,             // APB ready
	output logic             pslverr_out,            // APB error
	input  wire logic        dedicated_irq_pin_in,   // Dedicated pin level
	input  wire logic [15:0] pin_change_inputs_in,   // Pin-change inputs
	input  wire logic        global_irq_enable_in,   // CPU global enable
	input  wire logic [2:0]  vector_start_in,        // Routine start: up,lo,ded
	output logic             dedicated_irq_req_out,  // Dedicated request
	output logic             upper_group_request_out,// Upper group request
	output logic             lower_group_request_out,// Lower group request
	output logic             wake_out                // Pin activity seen
);

	// ==========================================================
	// Declarations
	epci_pkg::epci_ctrl_t  ctrl;        // Control registers
	epci_pkg::epci_flags_t flags;       // Sticky flags
	logic [15:0] pc_s1;                 // Change sync stage one
	logic [15:0] pc_s2;                 // Change sync stage two
	logic [15:0] pc_prev;               // Previous synced level
	logic        ded_s1;                // Pin sync stage one
	logic        ded_s2;                // Pin sync stage two
	logic        ded_prev;              // Previous synced pin
	logic [15:0] pc_toggle;             // Per-input toggle seen
	logic        up_hit;                // Unmasked upper toggle
	logic        lo_hit;                // Unmasked lower toggle
	logic        ded_hit;               // Edge matching sense
	logic        level_mode;            // Sense set to low level
	logic        wr_take;               // Write takes effect
	logic        rd_take;               // Read data launches
	logic        addr_ok;               // Address decodes
	logic [31:0] rd_word;               // Decoded read value
	logic [7:0]  w1c;                   // Clear bits written

	// ==========================================================
	// Pin synchronisers, two stages each
	// sync before flags
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pc_s1  <= 16'h0000;
			pc_s2  <= 16'h0000;
			ded_s1 <= 1'b1;
			ded_s2 <= 1'b1;
		end else begin
			pc_s1  <= pin_change_inputs_in;
			pc_s2  <= pc_s1;
			ded_s1 <= dedicated_irq_pin_in;
			ded_s2 <= ded_s1;
		end
	end

	// ==========================================================
	// Previous-level history for change detection
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pc_prev  <= 16'h0000;
			ded_prev <= 1'b1;
		end else begin
			pc_prev  <= pc_s2;
			ded_prev <= ded_s2;
		end
	end

	// ==========================================================
	// Event decode
	// pin levels read whatever the direction
	always_comb begin
		pc_toggle  = pc_s2 ^ pc_prev;
		level_mode = (ctrl.sense == `EPCI_SENSE_LOW);
		up_hit = |(pc_toggle[15:8] & ctrl.mask_up);
		lo_hit = |(pc_toggle[7:0] & ctrl.mask_lo);
		case (ctrl.sense)
			`EPCI_SENSE_ANY:  ded_hit = ded_s2 ^ ded_prev;
			`EPCI_SENSE_FALL: ded_hit = ded_prev & ~ded_s2;
			`EPCI_SENSE_RISE: ded_hit = ~ded_prev & ded_s2;
			default:          ded_hit = 1'b0;
		endcase
	end

	// ==========================================================
	// APB decode
	always_comb begin
		wr_take = psel_in & penable_in & pready_out & pwrite_in;
		rd_take = psel_in & penable_in & ~pready_out & ~pwrite_in;
		addr_ok = 1'b1;
		rd_word = `EPCI_ZERO_WORD;
		if (paddr_in == `EPCI_OFF_SENSE) begin
			rd_word[1:0] = ctrl.sense;
		end else if (paddr_in == `EPCI_OFF_ENABLE) begin
			rd_word[`EPCI_BIT_UPPER] = ctrl.en_up;
			rd_word[`EPCI_BIT_LOWER] = ctrl.en_lo;
			rd_word[`EPCI_BIT_DED]   = ctrl.en_ded;
		end else if (paddr_in == `EPCI_OFF_FLAG) begin
			rd_word[`EPCI_BIT_UPPER] = flags.up;
			rd_word[`EPCI_BIT_LOWER] = flags.lo;
			rd_word[`EPCI_BIT_DED]   = flags.ded;
		end else if (paddr_in == `EPCI_OFF_MASK_UP) begin
			rd_word[7:0] = ctrl.mask_up;
		end else if (paddr_in == `EPCI_OFF_MASK_LO) begin
			rd_word[7:0] = ctrl.mask_lo;
		end else begin
			// Unmapped: zero data, error
			addr_ok = 1'b0;
		end
		// ones written to flag clear it
		w1c = (wr_take && paddr_in == `EPCI_OFF_FLAG) ? pwdata_in[7:0] : `EPCI_RST_BYTE;
	end

	// ==========================================================
	// APB handshake; one wait state keeps outputs registered
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= `EPCI_ZERO_WORD;
		end else begin
			pready_out  <= psel_in & penable_in & ~pready_out;
			pslverr_out <= psel_in & penable_in & ~pready_out & ~addr_ok;
			if (rd_take) begin
				prdata_out <= rd_word;
			end
		end
	end

	// ==========================================================
	// Control register writes
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl.sense   <= `EPCI_RST_SENSE;
			ctrl.en_up   <= 1'b0;
			ctrl.en_lo   <= 1'b0;
			ctrl.en_ded  <= 1'b0;
			ctrl.mask_up <= `EPCI_RST_BYTE;
			ctrl.mask_lo <= `EPCI_RST_BYTE;
		end else if (wr_take) begin
			if (paddr_in == `EPCI_OFF_SENSE) begin
				ctrl.sense <= pwdata_in[1:0];
			end else if (paddr_in == `EPCI_OFF_ENABLE) begin
				ctrl.en_up  <= pwdata_in[`EPCI_BIT_UPPER];
				ctrl.en_lo  <= pwdata_in[`EPCI_BIT_LOWER];
				ctrl.en_ded <= pwdata_in[`EPCI_BIT_DED];
			end else if (paddr_in == `EPCI_OFF_MASK_UP) begin
				ctrl.mask_up <= pwdata_in[7:0];
			end else if (paddr_in == `EPCI_OFF_MASK_LO) begin
				ctrl.mask_lo <= pwdata_in[7:0];
			end
		end
	end

	// ==========================================================
	// Sticky flags; a set in the clearing cycle wins
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags <= 3'h0;
		end else begin
			if (up_hit) begin
				flags.up <= 1'b1;
			end else if (w1c[`EPCI_BIT_UPPER] | vector_start_in[2]) begin
				flags.up <= 1'b0;
			end
			// Lower group flag
			if (lo_hit) begin
				flags.lo <= 1'b1;
			end else if (w1c[`EPCI_BIT_LOWER] | vector_start_in[1]) begin
				flags.lo <= 1'b0;
			end
			if (level_mode) begin
				flags.ded <= 1'b0;
			end else if (ded_hit) begin
				flags.ded <= 1'b1;
			end else if (w1c[`EPCI_BIT_DED] | vector_start_in[0]) begin
				flags.ded <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Requests toward the CPU, each its own vector
	// separate group requests
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dedicated_irq_req_out   <= 1'b0;
			upper_group_request_out <= 1'b0;
			lower_group_request_out <= 1'b0;
			wake_out                <= 1'b0;
		end else begin
			upper_group_request_out <= flags.up & ctrl.en_up & global_irq_enable_in;
			lower_group_request_out <= flags.lo & ctrl.en_lo & global_irq_enable_in;
			if (level_mode) begin
				dedicated_irq_req_out <= ~ded_s2 & ctrl.en_ded & global_irq_enable_in;
			end else begin
				dedicated_irq_req_out <= flags.ded & ctrl.en_ded & global_irq_enable_in;
			end
			// Activity indicator for power control
			wake_out <= up_hit | lo_hit | ded_hit | (level_mode & ~ded_s2);
		end
	end

	// ==========================================================
	// Assertions
	sequence s_access;
		psel_in && penable_in && !pready_out;
	endsequence

	sequence s_answer;
		pready_out ##1 !pready_out;
	endsequence

	property p_apb_answer;
		@(posedge clk_in) disable iff (rst_in)
		s_access |=> s_answer;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("APB ready not one cycle late");

	property p_upper_flag;
		@(posedge clk_in) disable iff (rst_in)
		$rose(pc_s2[8]) && pc_prev[8] == 1'b0 && ctrl.mask_up[0] |=> flags.up;
	endproperty
	a_upper_flag: assert property (p_upper_flag) else $error("Upper toggle lost");

	property p_lower_flag;
		@(posedge clk_in) disable iff (rst_in)
		lo_hit |=> flags.lo;
	endproperty
	a_lower_flag: assert property (p_lower_flag) else $error("Lower toggle lost");

	property p_mask_block;
		@(posedge clk_in) disable iff (rst_in)
		$rose(flags.up) |-> $past(|(pc_toggle[15:8] & ctrl.mask_up));
	endproperty
	a_mask_block: assert property (p_mask_block) else $error("Masked input set flag");

	property p_level_clear;
		@(posedge clk_in) disable iff (rst_in)
		ctrl.sense == `EPCI_SENSE_LOW |=> !flags.ded;
	endproperty
	a_level_clear: assert property (p_level_clear) else $error("Flag set in level mode");

	property p_level_req;
		@(posedge clk_in) disable iff (rst_in)
		level_mode && !ded_s2 && ctrl.en_ded && global_irq_enable_in |=> dedicated_irq_req_out;
	endproperty
	a_level_req: assert property (p_level_req) else $error("Low level not requested");

	property p_fall_edge;
		@(posedge clk_in) disable iff (rst_in)
		ctrl.sense == `EPCI_SENSE_FALL && ded_prev && !ded_s2 |=> flags.ded;
	endproperty
	a_fall_edge: assert property (p_fall_edge) else $error("Falling edge missed");

	property p_w1c;
		@(posedge clk_in) disable iff (rst_in)
		w1c[`EPCI_BIT_LOWER] && !lo_hit |=> !flags.lo;
	endproperty
	a_w1c: assert property (p_w1c) else $error("Write one did not clear");

	property p_gate_upper;
		@(posedge clk_in) disable iff (rst_in)
		upper_group_request_out |-> $past(ctrl.en_up && global_irq_enable_in);
	endproperty
	a_gate_upper: assert property (p_gate_upper) else $error("Upper request ungated");

	property p_ded_gate;
		@(posedge clk_in) disable iff (rst_in)
		dedicated_irq_req_out |-> $past(ctrl.en_ded && global_irq_enable_in);
	endproperty
	a_ded_gate: assert property (p_ded_gate) else $error("Dedicated request ungated");

	property p_vector_clear;
		@(posedge clk_in) disable iff (rst_in)
		vector_start_in[0] && !ded_hit && !level_mode |=> !flags.ded;
	endproperty
	a_vector_clear: assert property (p_vector_clear) else $error("Routine start kept flag");

	// Synchronised pin low twice in a row, rise sensing
	sequence s_rise_low;
		ctrl.sense == `EPCI_SENSE_RISE && !ded_s2 && !ded_prev;
	endsequence

	// Synchronised pin now high, still rise sensing
	sequence s_rise_high;
		ctrl.sense == `EPCI_SENSE_RISE && ded_s2;
	endsequence

	// Only the second stage is watched; the first may be metastable
	property p_pin_sync;
		@(posedge clk_in) disable iff (rst_in)
		s_rise_low ##1 s_rise_high |=> flags.ded;
	endproperty
	a_pin_sync: assert property (p_pin_sync) else $error("Rising pulse missed");

	property p_gate_lower;
		@(posedge clk_in) disable iff (rst_in)
		lower_group_request_out |-> $past(ctrl.en_lo && global_irq_enable_in);
	endproperty
	a_gate_lower: assert property (p_gate_lower) else $error("Lower request ungated");

	property p_upper_req;
		@(posedge clk_in) disable iff (rst_in)
		flags.up && ctrl.en_up && global_irq_enable_in |=> upper_group_request_out;
	endproperty
	a_upper_req: assert property (p_upper_req) else $error("Upper request not raised");

	property p_vector_upper;
		@(posedge clk_in) disable iff (rst_in)
		vector_start_in[2] && !up_hit |=> !flags.up;
	endproperty
	a_vector_upper: assert property (p_vector_upper) else $error("Upper routine start kept flag");

	property p_level_release;
		@(posedge clk_in) disable iff (rst_in)
		level_mode && ded_s2 |=> !dedicated_irq_req_out;
	endproperty
	a_level_release: assert property (p_level_release) else $error("High pin still requested");

	property p_any_edge;
		@(posedge clk_in) disable iff (rst_in)
		ctrl.sense == `EPCI_SENSE_ANY && ded_s2 != ded_prev |=> flags.ded;
	endproperty
	a_any_edge: assert property (p_any_edge) else $error("Pin change missed");

	property p_wake_level;
		@(posedge clk_in) disable iff (rst_in)
		level_mode && !ded_s2 |=> wake_out;
	endproperty
	a_wake_level: assert property (p_wake_level) else $error("Low level gave no wake");

endmodule : epci_top

`default_nettype wire
